/* rtl/sram3_pkg.sv */
package sram3_pkg;

    // ------------------------------------------------------------------
    // register map (apb byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_ADDR        = 8'h00; // wait states, exceptions, turn-off
    localparam logic [7:0] STATE_ADDR      = 8'h04; // current sequencer state
    localparam logic [7:0] COLCNT_ADDR     = 8'h08; // completed column accesses
    localparam logic [7:0] RDDATA_ADDR     = 8'h0C; // low word of last read data

    // ------------------------------------------------------------------
    // configuration field layout and reset value
    // ------------------------------------------------------------------
    localparam int         WS_LSB          = 0;     // wait_state_count[1:0]
    localparam int         EXC_BIT         = 2;     // exception enable
    localparam int         RTO_LSB         = 4;     // extra turn-off states [7:4]
    localparam logic [7:0] CFG_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // pin encodings, kept as constants since the memory side may differ
    // ------------------------------------------------------------------
    localparam logic [1:0] STATUS_COLUMN   = 2'h1;  // column access beginning
    localparam logic [1:0] STATUS_IDLE     = 2'h0;  // no column access beginning
    localparam logic       STROBE_ACT_LOW  = 1'b1;  // byte strobes active low
    localparam logic [7:0] STROBE_OFF      = STROBE_ACT_LOW ? 8'hFF : 8'h00;

    // ------------------------------------------------------------------
    // extra cycles between second address state and first column stage
    // ------------------------------------------------------------------
    localparam logic [1:0] EXI_WRITE       = 2'h2;  // write: gap grows 3 -> 5
    localparam logic [1:0] EXI_READ        = 2'h1;  // read: gap grows 2 -> 3

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        address_state_first, address_state_second, exc_return_state,
        row_latch_state, row_to_col_state, exc_insert_state,
        column_stage_first, column_stage_second, column_stage_third,
        column_idle_stage, turn_off_state
    } seq_state_t;

    // access (page) request from the transfer engine
    typedef struct packed {
        logic        write;   // 1 = write access
        logic        periph;  // peripheral packet-transfer write
        logic [16:0] row;     // row address
    } acc_req_t;

    // one column of the current page
    typedef struct packed {
        logic [16:0] addr;     // column address
        logic [63:0] data;     // write data
        logic [7:0]  be;       // valid byte lanes
        logic        page_end; // last column of this page
    } col_req_t;

endpackage

/* rtl/sram3_seq.sv */
`timescale 1ns/1ps
`default_nettype none

module sram3_seq (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // transfer engine side
    input  wire logic                 acc_valid,
    input  wire sram3_pkg::acc_req_t  acc_req,
    output logic                      acc_ack,
    input  wire logic                 col_valid,
    input  wire sram3_pkg::col_req_t  col_req,
    output logic                      col_ack,
    output logic [63:0]               rd_data,
    output logic                      rd_valid,
    // memory side
    input  wire logic                 ready,
    input  wire logic                 exception_in,
    input  wire logic [63:0]          ad_in,
    output logic [63:0]               ad_out,
    output logic                      ad_oe,
    output logic                      transceiver_enable_n,
    output logic [16:0]               row_column_address_bus,
    output logic [1:0]                status,
    output logic [7:0]                byte_strobe
);
    import sram3_pkg::*;

    // ------------------------------------------------------------------
    // state and working registers
    // ------------------------------------------------------------------
    seq_state_t  state_reg;       // sequencer state
    seq_state_t  state_next;      // next sequencer state
    acc_req_t    acc_reg;         // page in progress
    col_req_t    col_reg;         // column in the pipeline
    logic [7:0]  cfg_reg;         // software configuration
    logic [1:0]  ws_left_reg;     // programmed c3 repeats still due
    logic [1:0]  exi_left_reg;    // exception insert states still due
    logic [3:0]  rto_left_reg;    // extra turn-off states still due
    logic [15:0] colcnt_reg;      // completed columns, wraps
    logic [1:0]  wait_state_count;
    logic        exc_en;
    logic [1:0]  exi_need;        // insert states this access needs
    logic        c3_done;         // last c3 of the column ends now
    logic        turn_off;        // access ends through turn-off states

    assign wait_state_count = cfg_reg[WS_LSB +: 2];
    assign exc_en           = cfg_reg[EXC_BIT];
    assign exi_need         = !exc_en ? 2'h0 : (acc_reg.write ? EXI_WRITE : EXI_READ);
    assign c3_done          = (state_reg == column_stage_third) && ready
                              && (ws_left_reg == 2'h0);
    assign turn_off         = !acc_reg.write || acc_reg.periph;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // a column is only loaded when it is present; otherwise we idle,
    // which is exactly how a bubble stretches the column idle time
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            address_state_first: begin
                if (acc_valid) begin
                    state_next = address_state_second;
                end
            end
            address_state_second: begin
                if (exc_en && exception_in) begin
                    state_next = exc_return_state;
                end else if (ready) begin
                    state_next = row_latch_state;
                end
            end
            exc_return_state: begin
                state_next = address_state_first;
            end
            row_latch_state: begin
                if (acc_reg.write) begin
                    state_next = row_to_col_state;
                end else if (exi_need != 2'h0) begin
                    state_next = exc_insert_state;
                end else begin
                    state_next = col_valid ? column_stage_first : column_idle_stage;
                end
            end
            row_to_col_state: begin
                if (!ready) begin
                    state_next = row_to_col_state;
                end else if (exi_need != 2'h0) begin
                    state_next = exc_insert_state;
                end else begin
                    state_next = col_valid ? column_stage_first : column_idle_stage;
                end
            end
            exc_insert_state: begin
                if (exi_left_reg == 2'h1) begin
                    state_next = col_valid ? column_stage_first : column_idle_stage;
                end
            end
            column_stage_first: begin
                if (ready) begin
                    state_next = column_stage_second;
                end
            end
            column_stage_second: begin
                state_next = column_stage_third;
            end
            column_stage_third: begin
                if (c3_done) begin
                    if (col_reg.page_end) begin
                        state_next = turn_off ? turn_off_state : address_state_first;
                    end else begin
                        state_next = col_valid ? column_stage_first : column_idle_stage;
                    end
                end
            end
            column_idle_stage: begin
                if (col_valid) begin
                    state_next = column_stage_first;
                end
            end
            turn_off_state: begin
                if (rto_left_reg == 4'h0) begin
                    state_next = address_state_first;
                end
            end
            default: begin
                state_next = address_state_first;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= address_state_first;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------------
    // page request taken on leaving ad1; an aborted access comes back
    // to ad1 and is taken again, so the source must hold it until ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= '0;
            acc_ack <= 1'b0;
        end else begin
            acc_ack <= 1'b0;
            if (state_reg == address_state_first && acc_valid) begin
                acc_reg <= acc_req;
            end
            if (state_reg == address_state_second && state_next == row_latch_state) begin
                acc_ack <= 1'b1;
            end
        end
    end

    // column taken on every entry to c1, never while one is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_reg <= '0;
            col_ack <= 1'b0;
        end else begin
            col_ack <= 1'b0;
            if (state_next == column_stage_first && state_reg != column_stage_first) begin
                col_reg <= col_req;
                col_ack <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // repeat counters
    // ------------------------------------------------------------------
    // programmed c3 repeats only count on high ready samples, so ready
    // waits add on top of them rather than overlapping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ws_left_reg <= 2'h0;
        end else if (state_next == column_stage_third && state_reg != column_stage_third) begin
            ws_left_reg <= wait_state_count;
        end else if (state_reg == column_stage_third && ready && ws_left_reg != 2'h0) begin
            ws_left_reg <= ws_left_reg - 2'h1;
        end
    end

    // exception insert states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exi_left_reg <= 2'h0;
        end else if (state_next == exc_insert_state && state_reg != exc_insert_state) begin
            exi_left_reg <= exi_need;
        end else if (state_reg == exc_insert_state) begin
            exi_left_reg <= exi_left_reg - 2'h1;
        end
    end

    // extra turn-off states from the configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rto_left_reg <= 4'h0;
        end else if (state_next == turn_off_state && state_reg != turn_off_state) begin
            rto_left_reg <= cfg_reg[RTO_LSB +: 4];
        end else if (state_reg == turn_off_state && rto_left_reg != 4'h0) begin
            rto_left_reg <= rto_left_reg - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // memory pins, registered from the next state
    // ------------------------------------------------------------------
    // single clock means half-cycle strobe edges are moved to the end
    // of the stage: on after c1, off after the final c3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_column_address_bus <= '0;
            status                 <= STATUS_IDLE;
            byte_strobe            <= STROBE_OFF;
            ad_out                 <= '0;
            ad_oe                  <= 1'b0;
            transceiver_enable_n   <= 1'b1;
        end else begin
            status      <= STATUS_IDLE;
            byte_strobe <= STROBE_OFF;
            ad_oe       <= 1'b0;
            transceiver_enable_n <= 1'b1;
            unique case (state_next)
                address_state_first, address_state_second, row_latch_state,
                row_to_col_state, exc_insert_state: begin
                    row_column_address_bus <= (state_next == address_state_first
                        && acc_valid && state_reg == address_state_first)
                        ? acc_req.row : acc_reg.row;
                end
                column_stage_first, column_stage_second, column_stage_third: begin
                    row_column_address_bus <= (state_next == column_stage_first
                        && state_reg != column_stage_first) ? col_req.addr : col_reg.addr;
                    if (state_next == column_stage_first) begin
                        status <= STATUS_COLUMN;
                    end
                    if (state_next != column_stage_first) begin
                        byte_strobe <= STROBE_ACT_LOW ?
                            ~(acc_reg.write ? col_reg.be : 8'hFF) :
                             (acc_reg.write ? col_reg.be : 8'hFF);
                    end
                    if (acc_reg.write && !acc_reg.periph) begin
                        ad_oe                <= 1'b1;
                        transceiver_enable_n <= 1'b0;
                        if (state_next == column_stage_first && state_reg != column_stage_first) begin
                            ad_out <= col_req.data;
                        end
                    end else if (!acc_reg.write) begin
                        transceiver_enable_n <= 1'b0;
                    end
                end
                default: begin
                    row_column_address_bus <= row_column_address_bus;
                end
            endcase
        end
    end

    // read capture after the final c3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= c3_done && !acc_reg.write;
            if (c3_done && !acc_reg.write) begin
                rd_data <= ad_in;
            end
        end
    end

    // column counter, seen by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            colcnt_reg <= 16'h0000;
        end else if (c3_done) begin
            colcnt_reg <= colcnt_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // apb slave: no wait cycles, pready is high in the first access-phase cycle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    CFG_ADDR:    prdata <= {24'h000000, cfg_reg};
                    STATE_ADDR:  prdata <= {28'h0000000, state_reg};
                    COLCNT_ADDR: prdata <= {16'h0000, colcnt_reg};
                    RDDATA_ADDR: prdata <= rd_data[31:0];
                    default:     pslverr <= 1'b1;
                endcase
            end
        end
    end

    // configuration write at the completing access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RESET;
        end else if (psel && penable && pready && pwrite && paddr == CFG_ADDR) begin
            cfg_reg <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_c1_wait;
        state_reg == column_stage_first && !ready
            |=> state_reg == column_stage_first && byte_strobe == STROBE_OFF;
    endproperty
    a_c1_wait: assert property (p_c1_wait) else $error("c1 wait not repeated");

    property p_c1_to_c3;
        state_reg == column_stage_first && ready
            |=> state_reg == column_stage_second ##1 state_reg == column_stage_third;
    endproperty
    a_c1_to_c3: assert property (p_c1_to_c3) else $error("column stages out of order");

    property p_ws_three;
        (state_reg == column_stage_second && wait_state_count == 2'h3)
            ##1 (state_reg == column_stage_third && ready)[*3]
            |=> state_reg == column_stage_third;
    endproperty
    a_ws_three: assert property (p_ws_three) else $error("c3 left too early");

    property p_abort;
        state_reg == address_state_second && exc_en && exception_in
            |=> state_reg == exc_return_state ##1 state_reg == address_state_first;
    endproperty
    a_abort: assert property (p_abort) else $error("exception did not abort");

    property p_ad2_wait;
        state_reg == address_state_second && !ready && !(exc_en && exception_in)
            |=> state_reg == address_state_second;
    endproperty
    a_ad2_wait: assert property (p_ad2_wait) else $error("ad2 not repeated");

    property p_exc_gap;
        state_reg == address_state_second && state_next == row_latch_state
            && exc_en && acc_reg.write
            |=> (state_reg != column_stage_first)[*4];
    endproperty
    a_exc_gap: assert property (p_exc_gap) else $error("column too soon");

    property p_idle_pins;
        state_reg == column_idle_stage
            |-> status == STATUS_IDLE && byte_strobe == STROBE_OFF && !ad_oe;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("idle pins wrong");

    property p_periph_bus;
        acc_reg.write && acc_reg.periph && state_reg == column_stage_second
            |-> !ad_oe && transceiver_enable_n;
    endproperty
    a_periph_bus: assert property (p_periph_bus) else $error("bus driven on peripheral write");

    property p_turn_off;
        c3_done && col_reg.page_end && acc_reg.write && acc_reg.periph
            |=> state_reg == turn_off_state;
    endproperty
    a_turn_off: assert property (p_turn_off) else $error("turn-off state missing");

    property p_rd_capture;
        c3_done && !acc_reg.write |=> rd_valid && rd_data == $past(ad_in);
    endproperty
    a_rd_capture: assert property (p_rd_capture) else $error("read data not captured");

    c_c1_wait:  cover property (state_reg == column_stage_first && !ready);
    c_ws_three: cover property (state_reg == column_stage_third && ws_left_reg == 2'h3);
    c_bubble:   cover property (state_reg == column_stage_third ##1 state_reg == column_idle_stage);
    c_abort:    cover property (state_reg == exc_return_state);

endmodule

`default_nettype wire

/* dv/sram3_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// slow sram model with its ready logic
// ----------------------------------------------------------------
module sram3_mem (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [1:0]  status,
    input  wire logic [7:0]  byte_strobe,
    input  wire logic [63:0] ad_out,
    input  wire logic [31:0] stall,
    output logic             ready,
    output logic [63:0]      ad_in,
    output logic [63:0]      mem_word
);
    import sram3_pkg::*;
    logic was_col; // column status seen one cycle ago
    int   cnt;     // low ready cycles still owed
    logic first;   // first cycle of a column stage one
    assign first = (status == STATUS_COLUMN) && !was_col && (stall != 0);
    // low ready from the first column cycle, one repeat per low sample
    assign ready = (cnt == 0) && !first;
    // the model never drives read data, so show a value that differs from the last word
    assign ad_in = ~mem_word;
    // stall counting and data capture while strobes are active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            was_col  <= 1'b0;
            cnt      <= 0;
            mem_word <= 64'h0;
        end else begin
            was_col <= (status == STATUS_COLUMN);
            if (first) cnt <= stall - 1;
            else if (cnt != 0) cnt <= cnt - 1;
            if (byte_strobe != STROBE_OFF) mem_word <= ad_out;
        end
    end
endmodule
`default_nettype wire

/* dv/test_sram3_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("unexpected t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
// ----------------------------------------------------------------
// bench: one single-column write page per row
// ----------------------------------------------------------------
module test_sram3_seq;
    import sram3_pkg::*;
    typedef struct { logic [7:0] cfg; int stall; int xc; logic per; int gap; int lead; int son; } row_t;
    localparam logic [63:0] WDATA = 64'hA5A5_0F0F_1234_5678; // column write word
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, acc_valid, acc_ack;
    logic col_valid, col_ack, rd_valid, ready, exception_in, ad_oe, transceiver_enable_n;
    logic [7:0] paddr, byte_strobe;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] rd_data, ad_in, ad_out, mem_word;
    logic [16:0] row_column_address_bus;
    logic [1:0] status;
    logic e;
    acc_req_t acc_req;
    col_req_t col_req;
    int stall, bad_count, num_checks, cyc;
    // cfg, stall, exception cycles, periph, ack gap, strobe lead, strobe cycles
    row_t rows[7] = '{'{8'h00, 0, 0, 1'b0, 2, 1, 2}, '{8'h01, 0, 0, 1'b0, 2, 1, 3},
        '{8'h02, 1, 0, 1'b0, 2, 2, 4}, '{8'h03, 2, 0, 1'b0, 2, 3, 5},
        '{8'h04, 0, 0, 1'b0, 4, 1, 2}, '{8'h04, 0, 9, 1'b0, 4, 1, 2},
        '{8'h10, 0, 0, 1'b1, 2, 1, 2}};
    sram3_seq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .acc_valid, .acc_req, .acc_ack, .col_valid, .col_req, .col_ack,
        .rd_data, .rd_valid, .ready, .exception_in, .ad_in, .ad_out, .ad_oe,
        .transceiver_enable_n, .row_column_address_bus, .status, .byte_strobe);
    sram3_mem mem (.pclk, .presetn, .status, .byte_strobe, .ad_out, .stall, .ready, .ad_in,
        .mem_word);
    always #20 pclk = ~pclk;
    // a hang is cut short well beyond the few hundred cycles the rows need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // outputs are read at the edge, so each sample is the cycle that just ended
    task automatic run(input row_t r);
        int t, ta, tc, tf, son;
        apb(1'b1, CFG_ADDR, {24'h0, r.cfg});
        {ta, tc, tf, son} = '0;
        stall <= r.stall;
        exception_in <= (r.xc != 0);
        {acc_valid, col_valid} <= 2'b11;
        acc_req <= '{1'b1, r.per, 17'h00AB};
        col_req <= '{17'h01C3, WDATA, 8'hFF, 1'b1};
        for (t = 1; t < 80; t++) begin
            @(posedge pclk);
            if (t == r.xc) exception_in <= 1'b0;
            if (acc_ack === 1'b1) begin
                ta = t;
                acc_valid <= 1'b0;
            end
            if (col_ack === 1'b1) begin
                tc = t;
                col_valid <= 1'b0;
                `CHK(status, STATUS_COLUMN)
                if (!r.per) `CHK(ad_out, WDATA)
            end
            if (byte_strobe !== STROBE_OFF) begin
                if (tf == 0) tf = t;
                son++;
                `CHK(row_column_address_bus, 17'h01C3)
                `CHK(ad_oe, !r.per)
            end
            if (r.per) `CHK(transceiver_enable_n, 1'b1)
        end
        `CHK(ta > r.xc, 1'b1)
        `CHK(tc - ta, r.gap)
        `CHK(tf - tc, r.lead)
        `CHK(son, r.son)
        `CHK(status, STATUS_IDLE)
        `CHK(byte_strobe, STROBE_OFF)
        if (!r.per) `CHK(mem_word, WDATA)
        $display("test cfg %0h ready stall %0d done", r.cfg, r.stall);
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {acc_valid, col_valid, exception_in, acc_req, col_req, stall} = '0;
        {bad_count, num_checks, cyc} = '0;
        repeat (10) @(posedge pclk);
        `CHK(byte_strobe, STROBE_OFF)
        `CHK(status, STATUS_IDLE)
        presetn <= 1'b1;
        apb(1'b0, CFG_ADDR, 32'h0);
        `CHK(rd[7:0], CFG_RESET)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(e, 1'b1)
        $display("test reset and apb done");
        foreach (rows[i]) run(rows[i]);
        // one-column read page: the model answers with the inverse of its word
        acc_req <= '{1'b0, 1'b0, 17'h00AB};
        {acc_valid, col_valid} <= 2'b11;
        for (int t = 0; t < 40 && rd_valid !== 1'b1; t++) begin
            @(posedge pclk);
            if (acc_ack === 1'b1) acc_valid <= 1'b0;
            if (col_ack === 1'b1) col_valid <= 1'b0;
        end
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, ~WDATA)
        apb(1'b0, RDDATA_ADDR, 32'h0);
        `CHK(rd, ~WDATA[31:0])
        $display("test read page done");
        end_sim();
    end
endmodule
`default_nettype wire
